/* File: rtl/port_mux_defs.svh */
// Constants for the pin configuration multiplexer
`ifndef PORT_MUX_DEFS_SVH
`define PORT_MUX_DEFS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define PM_NPORTS 10
`define PM_NPINS 80
`define PM_PIN(p, b) ((p) * 8 + (b))

// ----------------------------------------------------------------
// Fixed pad characteristics, one bit per pin, port 9 in the top byte
// ----------------------------------------------------------------
`define PM_TTL_MASK 80'h0000_0000_0826_08CC_FFFF
`define PM_WPU_MASK 80'hFFFF_FF3F_082E_FEF3_0000
`define PM_PURE_OD_MASK 80'h0000_0000_00C0_000C_0000
`define PM_HYST_MASK 80'h0000_0030_0000_0000_0000
`define PM_RST_BIDIR 80'hFFFC_0000_0002_0000_FFFF
`define PM_RST_DATA 80'hFFFF_FFFF_FFFF_FFFF_FFFF

// ----------------------------------------------------------------
// Configuration codes {c2, c1, c0}
// ----------------------------------------------------------------
`define CODE_BIDIR 3'h0
`define CODE_IN_CMOS 3'h1
`define CODE_AF_IN 3'h5
`define CODE_AF_PP 3'h3
`define CODE_SPECIAL 3'h7
`define PORT_ADDR 4'h1
`define PORT_ADC 4'h7

// ----------------------------------------------------------------
// Alternate-function pin positions
// ----------------------------------------------------------------
`define P2_0 `PM_PIN(2, 0)
`define P2_1 `PM_PIN(2, 1)
`define P2_2 `PM_PIN(2, 2)
`define P2_3 `PM_PIN(2, 3)
`define P2_4 `PM_PIN(2, 4)
`define P2_5 `PM_PIN(2, 5)
`define P2_6 `PM_PIN(2, 6)
`define P2_7 `PM_PIN(2, 7)
`define P3_1 `PM_PIN(3, 1)
`define P3_2 `PM_PIN(3, 2)
`define P3_3 `PM_PIN(3, 3)
`define P3_4 `PM_PIN(3, 4)
`define P3_5 `PM_PIN(3, 5)
`define P3_6 `PM_PIN(3, 6)
`define P3_7 `PM_PIN(3, 7)
`define P5_2 `PM_PIN(5, 2)
`define P5_3 `PM_PIN(5, 3)

`endif

/* File: rtl/port_mux_pkg.sv */
// Types shared by both ends of the pin configuration multiplexer
`default_nettype none
package port_mux_pkg;

  typedef enum logic [1:0] {SEL_C0, SEL_C1, SEL_C2, SEL_DATA} cfg_sel_t;

  typedef enum logic [1:0] {ST_IDLE, ST_C0, ST_C1, ST_C2} ctl_state_t;

  typedef struct packed {
    logic sci;
    logic spi;
    logic spi_master;
    logic mft0;
    logic mft1;
    logic eft0;
    logic wake;
  } periph_en_t;

  typedef struct packed {
    logic       serial_tx_data_out;
    logic [3:0] mft_out;
    logic       eft0_compare_a;
    logic       eft0_compare_b;
    logic       spi_miso;
    logic       spi_mosi;
    logic       spi_sck;
    logic [7:0] muxed_addr_data_line;
    logic       mem_ad_oe;
    logic [7:0] mem_addr_hi;
  } periph_drive_t;

  typedef struct packed {
    logic       serial_rx_data_in;
    logic [3:0] mft_in;
    logic       eft0_capture_a;
    logic       eft0_capture_b;
    logic       eft0_ext_clock;
    logic       spi_ss;
    logic       spi_miso;
    logic       spi_mosi;
    logic       spi_sck;
    logic       wakeup_line_zero;
    logic [7:0] muxed_addr_data_line;
  } periph_sense_t;

endpackage
`default_nettype wire

/* File: rtl/port_mux_if.sv */
// Connection between the pin multiplexer and its configuring side
`default_nettype none
interface port_mux_if;
  logic                      cfg_wr;
  port_mux_pkg::cfg_sel_t    cfg_sel;
  logic [3:0]                cfg_port;
  logic [7:0]                cfg_data;
  logic [3:0]                rd_port;
  logic [7:0]                rd_data;
  port_mux_pkg::periph_en_t    en;
  port_mux_pkg::periph_drive_t drv;
  port_mux_pkg::periph_sense_t sns;

  modport dev (input cfg_wr, cfg_sel, cfg_port, cfg_data, rd_port, en, drv,
               output rd_data, sns);
  modport ctl (output cfg_wr, cfg_sel, cfg_port, cfg_data, rd_port, en, drv,
               input rd_data, sns);
endinterface
`default_nettype wire

/* File: rtl/pin_sync.sv */
// Three-stage pin input synchroniser with agreement filter
`default_nettype none
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         resetn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] q_r;
  wire  logic [W-1:0] agree = ~(s2_r ^ s3_r);

  // Idle high so pulled-up pins do not show a false low after reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
      q_r  <= '1;
    end else begin
      s1_r <= d_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (agree & s3_r) | (~agree & q_r);
    end
  end

  assign q_out = q_r;
endmodule
`default_nettype wire

/* File: rtl/pin_mux_dev.sv */
// Port pin configuration and alternate-function multiplexer
`include "port_mux_defs.svh"
`default_nettype none
module pin_mux_dev (
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  port_mux_if.dev                     bus,
  input  wire logic [`PM_NPINS-1:0]   pin_in_in,
  output logic      [`PM_NPINS-1:0]   pin_val_out,
  output logic      [`PM_NPINS-1:0]   pin_oe_out,
  output logic      [`PM_NPINS-1:0]   pin_pullup_out,
  output logic      [`PM_NPINS-1:0]   pin_ttl_out,
  output logic      [`PM_NPINS-1:0]   pin_schmitt_out,
  output logic      [`PM_NPINS-1:0]   pin_hyst_out,
  output logic      [7:0]             adc_channel_input_out
);
  localparam int NP = `PM_NPINS;
  localparam int NPORTS = `PM_NPORTS;

  // ----------------------------------------------------------------
  // Configuration and data registers
  // ----------------------------------------------------------------
  logic [NPORTS-1:0][7:0] c0_r;
  logic [NPORTS-1:0][7:0] c1_r;
  logic [NPORTS-1:0][7:0] c2_r;
  logic [NPORTS-1:0][7:0] dr_r;
  wire  logic wr_ok = bus.cfg_wr && (bus.cfg_port < 4'(NPORTS));

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      c0_r <= ~`PM_RST_BIDIR;
      c1_r <= '0;
      c2_r <= '0;
      dr_r <= `PM_RST_DATA;
    end else if (wr_ok) begin
      case (bus.cfg_sel)
        port_mux_pkg::SEL_C0: c0_r[bus.cfg_port] <= bus.cfg_data;
        port_mux_pkg::SEL_C1: c1_r[bus.cfg_port] <= bus.cfg_data;
        port_mux_pkg::SEL_C2: c2_r[bus.cfg_port] <= bus.cfg_data;
        default:              dr_r[bus.cfg_port] <= bus.cfg_data;
      endcase
    end
  end

  wire logic [NP-1:0] c0_f = c0_r;
  wire logic [NP-1:0] c1_f = c1_r;
  wire logic [NP-1:0] c2_f = c2_r;
  wire logic [NP-1:0] dr_f = dr_r;

  // ----------------------------------------------------------------
  // Pin input synchronisation
  // ----------------------------------------------------------------
  logic [NP-1:0] in_s;

  pin_sync #(.W(NP)) u_sync (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .d_in      (pin_in_in),
    .q_out     (in_s)
  );

  // ----------------------------------------------------------------
  // Alternate-function drive map
  // ----------------------------------------------------------------
  logic [NP-1:0] alt_val;
  logic [NP-1:0] alt_en;
  port_mux_pkg::periph_en_t    en;
  port_mux_pkg::periph_drive_t drv;
  assign en  = bus.en;
  assign drv = bus.drv;

  always_comb begin
    alt_val = '0;
    alt_en  = '0;
    alt_val[7:0]    = drv.muxed_addr_data_line;
    alt_en[7:0]     = {8{drv.mem_ad_oe}};
    alt_val[15:8]   = drv.mem_addr_hi;
    alt_en[15:8]    = '1;
    alt_val[`P5_3]  = drv.serial_tx_data_out;
    alt_en[`P5_3]   = en.sci;
    alt_val[`P2_2]  = drv.mft_out[0];
    alt_en[`P2_2]   = en.mft0;
    alt_val[`P2_3]  = drv.mft_out[1];
    alt_en[`P2_3]   = en.mft0;
    alt_val[`P2_6]  = drv.mft_out[2];
    alt_en[`P2_6]   = en.mft1;
    alt_val[`P2_7]  = drv.mft_out[3];
    alt_en[`P2_7]   = en.mft1;
    alt_val[`P3_2]  = drv.eft0_compare_a;
    alt_en[`P3_2]   = en.eft0;
    alt_val[`P3_3]  = drv.eft0_compare_b;
    alt_en[`P3_3]   = en.eft0;
    alt_val[`P3_5]  = drv.spi_miso;
    alt_en[`P3_5]   = en.spi & ~en.spi_master;
    alt_val[`P3_6]  = drv.spi_mosi;
    alt_en[`P3_6]   = en.spi & en.spi_master;
    alt_val[`P3_7]  = drv.spi_sck;
    alt_en[`P3_7]   = en.spi & en.spi_master;
  end

  // ----------------------------------------------------------------
  // Per-pin decode
  // ----------------------------------------------------------------
  logic [NP-1:0] val_n;
  logic [NP-1:0] oe_n;
  logic [NP-1:0] pu_n;
  logic [NP-1:0] ttl_n;
  logic [NP-1:0] smt_n;
  logic [NP-1:0] ana_n;
  wire  logic [NP-1:0] ttl_m  = `PM_TTL_MASK;
  wire  logic [NP-1:0] wpu_m  = `PM_WPU_MASK;
  wire  logic [NP-1:0] pod_m  = `PM_PURE_OD_MASK;

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_pin
      localparam logic [3:0] PORT = 4'(gi / 8);
      wire logic [2:0] code = {c2_f[gi], c1_f[gi], c0_f[gi]};
      wire logic special = (code == `CODE_SPECIAL);
      wire logic mem     = special && (PORT <= `PORT_ADDR);
      wire logic ana     = special && (PORT == `PORT_ADC);
      wire logic af      = code[1] & code[0] & ~ana;
      wire logic bid     = (code[1:0] == 2'h0);
      wire logic gpo     = (code[1:0] == 2'h2);
      wire logic inp     = (code[1:0] == 2'h1);
      wire logic val     = af ? alt_val[gi] : dr_f[gi];
      wire logic want    = af ? alt_en[gi] : (gpo | bid);
      wire logic pp_sel  = (af & (~code[2] | mem)) | (gpo & ~code[2]);
      // Without the upper transistor the pad can only pull low
      wire logic pp      = pp_sel & ~pod_m[gi];
      assign val_n[gi] = val;
      assign oe_n[gi]  = want & (pp | ~val);
      assign pu_n[gi]  = bid & wpu_m[gi] & ~pod_m[gi];
      assign ttl_n[gi] = ttl_m[gi] & code[2] & inp;
      assign smt_n[gi] = ~ttl_m[gi] & ~ana;
      assign ana_n[gi] = ana;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Peripheral inputs, connected by enable alone (SPI SCK also needs slave mode); the address/data lines are always connected
  // ----------------------------------------------------------------
  wire logic [NP-1:0] in_dig = in_s & ~ana_n;
  port_mux_pkg::periph_sense_t sns_n;

  always_comb begin
    sns_n = '0;
    sns_n.serial_rx_data_in = en.sci ? in_dig[`P5_2] : 1'b1;
    sns_n.mft_in = {in_dig[`P2_5], in_dig[`P2_4], in_dig[`P2_1], in_dig[`P2_0]}
                 & {{2{en.mft1}}, {2{en.mft0}}};
    sns_n.eft0_capture_b = en.eft0 & in_dig[`P3_1];
    sns_n.eft0_capture_a = en.eft0 & in_dig[`P3_2];
    sns_n.eft0_ext_clock = en.eft0 & in_dig[`P3_4];
    sns_n.spi_ss   = en.spi ? in_dig[`P3_4] : 1'b1;
    sns_n.spi_miso = en.spi & in_dig[`P3_5];
    sns_n.spi_mosi = en.spi & in_dig[`P3_6];
    sns_n.spi_sck  = en.spi & ~en.spi_master & in_dig[`P3_7];
    sns_n.wakeup_line_zero = en.wake & in_dig[`P3_7];
    sns_n.muxed_addr_data_line = in_dig[7:0];
  end

  function automatic logic [7:0] port_byte(input logic [NP-1:0] v, input logic [3:0] p);
    port_byte = (p < 4'(NPORTS)) ? v[p * 8 +: 8] : 8'h00;
  endfunction

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  logic [NP-1:0] val_r;
  logic [NP-1:0] oe_r;
  logic [NP-1:0] pu_r;
  logic [NP-1:0] ttl_r;
  logic [NP-1:0] smt_r;
  logic [NP-1:0] hyst_r;
  logic [7:0]    adc_r;
  logic [7:0]    rd_r;
  port_mux_pkg::periph_sense_t sns_r;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      val_r  <= '1;
      oe_r   <= '0;
      pu_r   <= '0;
      ttl_r  <= '0;
      smt_r  <= '0;
      hyst_r <= '0;
      adc_r  <= '0;
      rd_r   <= '0;
      sns_r  <= '0;
    end else begin
      val_r  <= val_n;
      oe_r   <= oe_n;
      pu_r   <= pu_n;
      ttl_r  <= ttl_n;
      smt_r  <= smt_n;
      hyst_r <= `PM_HYST_MASK;
      adc_r  <= port_byte(ana_n, `PORT_ADC);
      rd_r   <= port_byte(in_dig, bus.rd_port);
      sns_r  <= sns_n;
    end
  end

  assign pin_val_out           = val_r;
  assign pin_oe_out            = oe_r;
  assign pin_pullup_out        = pu_r;
  assign pin_ttl_out           = ttl_r;
  assign pin_schmitt_out       = smt_r;
  assign pin_hyst_out          = hyst_r;
  assign adc_channel_input_out = adc_r;
  assign bus.rd_data           = rd_r;
  assign bus.sns               = sns_r;
endmodule
`default_nettype wire

/* File: rtl/pin_cfg_ctl.sv */
// Configuring side: pin mode commands, peripheral enables and drive
`include "port_mux_defs.svh"
`default_nettype none
module pin_cfg_ctl (
  input  wire logic                        clk_in,
  input  wire logic                        resetn_in,
  port_mux_if.ctl                          bus,
  input  wire logic                        cmd_valid_in,
  input  wire logic                        cmd_is_data_in,
  input  wire logic [3:0]                  cmd_port_in,
  input  wire logic [2:0]                  cmd_bit_in,
  input  wire logic [2:0]                  cmd_code_in,
  input  wire logic [7:0]                  cmd_data_in,
  input  wire logic [3:0]                  rd_port_in,
  input  wire port_mux_pkg::periph_en_t    en_in,
  input  wire port_mux_pkg::periph_drive_t drv_in,
  output logic                             busy_out,
  output logic                             conflict_out,
  output logic [7:0]                       rd_data_out,
  output logic [7:0]                       adc_ready_out,
  output port_mux_pkg::periph_sense_t      sns_out
);
  localparam int NPORTS = `PM_NPORTS;

  // ----------------------------------------------------------------
  // Shadow of the configuration codes
  // ----------------------------------------------------------------
  port_mux_pkg::ctl_state_t st_r;
  logic [NPORTS-1:0][7:0] sh0_r;
  logic [NPORTS-1:0][7:0] sh1_r;
  logic [NPORTS-1:0][7:0] sh2_r;
  logic [3:0]             port_r;
  logic                   wr_r;
  port_mux_pkg::cfg_sel_t sel_r;
  logic [7:0]             data_r;
  logic                   busy_r;
  wire  logic take = cmd_valid_in && (st_r == port_mux_pkg::ST_IDLE)
                     && (cmd_port_in < 4'(NPORTS));

  // Codes go out c0, c1, c2 in turn, so a pin may show mixed codes for two cycles
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r   <= port_mux_pkg::ST_IDLE;
      sh0_r  <= ~`PM_RST_BIDIR;
      sh1_r  <= '0;
      sh2_r  <= '0;
      port_r <= '0;
      wr_r   <= 1'b0;
      sel_r  <= port_mux_pkg::SEL_C0;
      data_r <= '0;
      busy_r <= 1'b0;
    end else begin
      wr_r <= 1'b0;
      case (st_r)
        port_mux_pkg::ST_IDLE: begin
          if (take && cmd_is_data_in) begin
            wr_r   <= 1'b1;
            sel_r  <= port_mux_pkg::SEL_DATA;
            port_r <= cmd_port_in;
            data_r <= cmd_data_in;
          end else if (take) begin
            sh0_r[cmd_port_in][cmd_bit_in] <= cmd_code_in[0];
            sh1_r[cmd_port_in][cmd_bit_in] <= cmd_code_in[1];
            sh2_r[cmd_port_in][cmd_bit_in] <= cmd_code_in[2];
            port_r <= cmd_port_in;
            busy_r <= 1'b1;
            st_r   <= port_mux_pkg::ST_C0;
          end
        end
        port_mux_pkg::ST_C0: begin
          wr_r   <= 1'b1;
          sel_r  <= port_mux_pkg::SEL_C0;
          data_r <= sh0_r[port_r];
          st_r   <= port_mux_pkg::ST_C1;
        end
        port_mux_pkg::ST_C1: begin
          wr_r   <= 1'b1;
          sel_r  <= port_mux_pkg::SEL_C1;
          data_r <= sh1_r[port_r];
          st_r   <= port_mux_pkg::ST_C2;
        end
        port_mux_pkg::ST_C2: begin
          wr_r   <= 1'b1;
          sel_r  <= port_mux_pkg::SEL_C2;
          data_r <= sh2_r[port_r];
          busy_r <= 1'b0;
          st_r   <= port_mux_pkg::ST_IDLE;
        end
        default: st_r <= port_mux_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Peripheral side: shared pins granted to one function only
  // ----------------------------------------------------------------
  // Timer clock and slave select share one pin, as do SCK and wake-up 0
  wire logic clash = (en_in.eft0 | en_in.wake) & en_in.spi;
  wire logic [7:0] adc_cfg = sh0_r[`PORT_ADC] & sh1_r[`PORT_ADC] & sh2_r[`PORT_ADC];
  port_mux_pkg::periph_en_t    en_r;
  port_mux_pkg::periph_drive_t drv_r;
  port_mux_pkg::periph_sense_t sns_r;
  logic       clash_r;
  logic [7:0] rd_r;
  logic [3:0] rdp_r;
  logic [7:0] adc_r;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      en_r    <= '0;
      drv_r   <= '0;
      sns_r   <= '0;
      clash_r <= 1'b0;
      rd_r    <= '0;
      rdp_r   <= '0;
      adc_r   <= '0;
    end else begin
      en_r      <= en_in;
      en_r.eft0 <= en_in.eft0 & ~en_in.spi;
      en_r.wake <= en_in.wake & ~en_in.spi;
      drv_r     <= drv_in;
      sns_r     <= bus.sns;
      clash_r   <= clash;
      rd_r      <= bus.rd_data;
      rdp_r     <= rd_port_in;
      adc_r     <= busy_r ? 8'h00 : adc_cfg;
    end
  end

  assign bus.cfg_wr   = wr_r;
  assign bus.cfg_sel  = sel_r;
  assign bus.cfg_port = port_r;
  assign bus.cfg_data = data_r;
  assign bus.rd_port  = rdp_r;
  assign bus.en       = en_r;
  assign bus.drv      = drv_r;
  assign busy_out     = busy_r;
  assign conflict_out = clash_r;
  assign rd_data_out  = rd_r;
  assign adc_ready_out = adc_r;
  assign sns_out      = sns_r;
endmodule
`default_nettype wire

/* File: verif/port_pin_config_mux_checker.sv */
// Interface checker for the pin configuration multiplexer
`default_nettype none
module port_pin_config_mux_checker (
  input wire logic                        clk_in,
  input wire logic                        resetn_in,
  input wire logic                        cfg_wr,
  input wire port_mux_pkg::cfg_sel_t      cfg_sel,
  input wire logic [3:0]                  cfg_port,
  input wire port_mux_pkg::periph_en_t    en,
  input wire port_mux_pkg::periph_sense_t sns
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ------------------------------------------------------------
  // Mode write steps
  // ------------------------------------------------------------
  sequence wr_c0; cfg_wr && cfg_sel == port_mux_pkg::SEL_C0; endsequence
  sequence wr_c1; cfg_wr && cfg_sel == port_mux_pkg::SEL_C1; endsequence
  sequence wr_c2; cfg_wr && cfg_sel == port_mux_pkg::SEL_C2; endsequence
  a_mode_order:
    assert property (wr_c0 |=> wr_c1 ##1 wr_c2) else $error("mode bytes out of order");
  a_mode_end:
    assert property (wr_c2 |=> !cfg_wr || cfg_sel == port_mux_pkg::SEL_DATA)
      else $error("write strobe after last byte");
  a_port_range:
    assert property (cfg_wr |-> cfg_port < 4'hA) else $error("write to missing port");
  // ------------------------------------------------------------
  // Peripheral inputs
  // ------------------------------------------------------------
  a_rx_idle:
    assert property ((!en.sci) [*3] |-> sns.serial_rx_data_in == 1'b1)
      else $error("serial input not idle");
  a_ss_idle:
    assert property ((!en.spi) [*3] |-> sns.spi_ss == 1'b1) else $error("select not idle");
  a_mft_off:
    assert property ((!en.mft0) [*3] |-> sns.mft_in[1:0] == 2'h0)
      else $error("timer input leaks");
  a_eft_off:
    assert property ((!en.eft0) [*3] |-> !sns.eft0_capture_b && !sns.eft0_ext_clock)
      else $error("extended timer input leaks");
  a_wake_off:
    assert property ((!en.wake) [*3] |-> !sns.wakeup_line_zero) else $error("wake leaks");
  // Shared pins may serve one function only
  a_one_function:
    assert property (en.spi |-> !en.eft0 && !en.wake) else $error("two functions on pin");
endmodule
`default_nettype wire

/* File: verif/port_pin_config_mux_bench.sv */
// Self-checking bench joining the controller and the pin multiplexer
`include "port_mux_defs.svh"
`default_nettype none
module port_pin_config_mux_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {int k; int p; logic [7:0] v; string nm;} note_t;
  localparam logic [79:0] TTLM = `PM_TTL_MASK;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_is_data = 1'b0;
  logic [3:0] cmd_port = 4'h0;
  logic [3:0] rd_port = 4'h0;
  logic [2:0] cmd_bit = 3'h0;
  logic [2:0] cmd_code = 3'h0;
  logic [7:0] cmd_data = 8'h00;
  logic [79:0] pin_in = 80'h0;
  logic [79:0] pin_val, pin_oe, pin_pu, pin_ttl, pin_st, pin_hy;
  logic [7:0] adc_in, rd_data, adc_rdy, d, seen;
  logic [3:0] m;
  logic busy, conflict;
  port_mux_pkg::periph_en_t en = '0;
  port_mux_pkg::periph_drive_t drv = '0;
  port_mux_pkg::periph_sense_t sns;
  note_t q[$];
  note_t nt;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  port_mux_if bus_if ();
  pin_mux_dev pin_mux_dev_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .bus(bus_if.dev), .pin_in_in(pin_in),
    .pin_val_out(pin_val), .pin_oe_out(pin_oe), .pin_pullup_out(pin_pu),
    .pin_ttl_out(pin_ttl), .pin_schmitt_out(pin_st), .pin_hyst_out(pin_hy),
    .adc_channel_input_out(adc_in));
  pin_cfg_ctl pin_cfg_ctl_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .bus(bus_if.ctl), .cmd_valid_in(cmd_valid),
    .cmd_is_data_in(cmd_is_data), .cmd_port_in(cmd_port), .cmd_bit_in(cmd_bit),
    .cmd_code_in(cmd_code), .cmd_data_in(cmd_data), .rd_port_in(rd_port), .en_in(en),
    .drv_in(drv), .busy_out(busy), .conflict_out(conflict), .rd_data_out(rd_data),
    .adc_ready_out(adc_rdy), .sns_out(sns));
  port_pin_config_mux_checker port_pin_config_mux_checker_i (
    .clk_in(clk_in), .resetn_in(resetn_in), .cfg_wr(bus_if.cfg_wr),
    .cfg_sel(bus_if.cfg_sel), .cfg_port(bus_if.cfg_port), .en(bus_if.en),
    .sns(bus_if.sns));

  always #25 clk_in = ~clk_in;

  function automatic logic [7:0] pick(int k, int p);
    case (k)
      0: return pin_val[p*8 +: 8];
      1: return pin_oe[p*8 +: 8];
      2: return pin_pu[p*8 +: 8];
      3: return pin_ttl[p*8 +: 8];
      4: return pin_st[p*8 +: 8];
      5: return pin_hy[p*8 +: 8];
      6: return adc_in;
      7: return rd_data;
      8: return adc_rdy;
      9: return {7'h00, sns.serial_rx_data_in};
      10: return {7'h00, sns.wakeup_line_zero};
      11: return {7'h00, conflict};
      default: return {7'h00, busy};
    endcase
  endfunction

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task automatic settle();
    repeat (8) @(posedge clk_in);
    #2;
  endtask

  task automatic check(input int k, input int p, input logic [7:0] v, input string nm);
    q.push_back('{k, p, v, nm});
  endtask

  // Next command is only taken four edges after the last one
  task automatic mode(input int p, input int b, input logic [2:0] c);
    cmd_valid = 1'b1;
    cmd_is_data = 1'b0;
    cmd_port = 4'(p);
    cmd_bit = 3'(b);
    cmd_code = c;
    @(posedge clk_in);
    #2;
    cmd_valid = 1'b0;
    repeat (3) @(posedge clk_in);
    #2;
  endtask

  task automatic mode_all(input int p, input logic [2:0] c);
    for (int b = 0; b < 8; b++) mode(p, b, c);
  endtask

  task automatic data(input int p, input logic [7:0] v);
    cmd_valid = 1'b1;
    cmd_is_data = 1'b1;
    cmd_port = 4'(p);
    cmd_data = v;
    @(posedge clk_in);
    #2;
    cmd_valid = 1'b0;
    @(posedge clk_in);
    #2;
  endtask

  task automatic close_out();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Result watcher and hang guard
  // ------------------------------------------------------------
  always @(negedge clk_in) begin
    while (q.size() > 0) begin
      nt = q.pop_front();
      seen = pick(nt.k, nt.p);
      n_compared++;
      if (seen !== nt.v) begin
        errors++;
        $display("wrong value %s port %0d expected %h seen %h", nt.nm, nt.p, nt.v, seen);
      end
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      close_out();
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(1));
    repeat (8) @(posedge clk_in);
    #2;
    resetn_in = 1'b1;
    // Live levels on the timer pins give the input masks something to block
    pin_in[31:16] = 16'($urandom);
    rd_port = 4'h2;
    settle();
    for (int p = 0; p < 10; p++) begin
      check(2, p, p == 4 ? 8'h02 : p == 8 ? 8'hFC : p == 9 ? 8'hFF : 8'h00, "pullup");
      check(1, p, 8'h00, "enable");
      check(4, p, ~TTLM[p*8 +: 8], "schmitt");
      check(5, p, p == 6 ? 8'h30 : 8'h00, "hyst");
    end
    check(7, 2, pin_in[23:16], "readback");
    // Level choice only sticks on pins without a Schmitt input
    mode_all(2, 3'h5);
    settle();
    check(3, 2, TTLM[23:16], "ttl");
    d = 8'($urandom);
    data(2, d);
    mode_all(2, 3'h2);
    settle();
    check(0, 2, d, "value");
    check(1, 2, 8'hF3 | (~d & 8'h0C), "enable");
    mode(2, 7, 3'h6);
    settle();
    check(1, 2, {~d[7], 7'h73} | (~d & 8'h0C), "enable");
    mode_all(2, 3'h0);
    settle();
    check(2, 2, 8'hF3, "pullup");
    m = 4'($urandom);
    en.mft1 = 1'b1;
    en.sci = 1'b1;
    drv.mft_out = m;
    drv.serial_tx_data_out = m[0];
    settle();
    check(0, 2, d, "value");
    mode(2, 6, 3'h3);
    mode(5, 3, 3'h3);
    mode(5, 2, 3'h5);
    settle();
    check(0, 2, {d[7], m[2], d[5:0]}, "value");
    check(0, 5, {4'hF, m[0], 3'h7}, "value");
    check(9, 0, 8'h00, "serial rx");
    en.sci = 1'b0;
    pin_in[`P3_7] = 1'b1;
    en.wake = 1'b1;
    settle();
    check(9, 0, 8'h01, "serial rx");
    check(10, 0, 8'h01, "wake");
    en.spi = 1'b1;
    settle();
    check(10, 0, 8'h00, "wake");
    check(11, 0, 8'h01, "conflict");
    d = 8'($urandom);
    drv.mem_ad_oe = 1'b1;
    drv.muxed_addr_data_line = d;
    mode_all(0, 3'h7);
    settle();
    check(0, 0, d, "value");
    check(1, 0, 8'hFF, "enable");
    pin_in[63:56] = 8'hFF;
    rd_port = 4'h7;
    mode_all(7, 3'h7);
    settle();
    check(6, 0, 8'hFF, "adc route");
    check(8, 0, 8'hFF, "adc ready");
    check(7, 0, 8'h00, "readback");
    check(4, 7, 8'h00, "schmitt");
    // Converter ready must drop while a rewrite of the port is under way
    fork
      mode(7, 0, 3'h7);
      begin
        repeat (2) @(posedge clk_in);
        #2;
        check(12, 0, 8'h01, "busy");
        check(8, 0, 8'h00, "adc ready");
      end
    join
    settle();
    check(8, 0, 8'hFF, "adc ready");
    @(negedge clk_in);
    #2;
    close_out();
  end
endmodule
`default_nettype wire
